// File: l2pi_far_model.sv
// Purpose: far side of the cache pins: tag compare logic or second processor
// Assumes: the tag compare outputs are always driven
// Notes: the second processor asks for the bus by a level
`timescale 1ns/10ps
module l2pi_far_model
(
    input  wire logic clk_i,
    input  wire logic cpu2_i,
    input  wire logic dpol_i,
    input  wire logic hpol_i,
    input  wire logic hit_want_i,
    input  wire logic dirty_want_i,
    input  wire logic req_want_i,
    input  wire logic agrant_i,
    input  wire logic dgrant_i,
    input  wire logic busy_i,
    input  wire logic retry_i,
    output logic      mod_req_o,
    output logic      hit_o,
    output logic      owns_o
);
    always_comb mod_req_o = cpu2_i ? req_want_i : (dirty_want_i ~^ dpol_i);
    // hit flag in the chosen polarity
    always_comb hit_o = hit_want_i ~^ hpol_i;
    // data bus taken only on a qualified grant
    always_ff @(posedge clk_i) owns_o <= cpu2_i & agrant_i & dgrant_i & ~busy_i & ~retry_i;
endmodule : l2pi_far_model

// File: l2pi_pkg.sv
// Purpose: constants for the secondary cache pin interface
// Assumes: classic wishbone register access, one clock
// Notes: pin roles switch with the configuration register
package l2pi_pkg;
    // register byte offsets
    localparam logic [7:0] ADDR_CFG    = 8'h00;
    localparam logic [7:0] ADDR_CMD    = 8'h04;
    localparam logic [7:0] ADDR_STATUS = 8'h08;
    // configuration field positions
    localparam int CFG_BURST     = 0;
    localparam int CFG_ONCHIP    = 1;
    localparam int CFG_CPU2      = 2;
    localparam int CFG_DIRTY_POL = 3;
    localparam int CFG_HIT_POL   = 4;
    localparam int CFG_MARK_POL  = 5;
    localparam int CFG_VALID_POL = 6;
    localparam int CFG_WIDTH     = 7;
    // reset: burst mode, external decode, cache mode, all active high
    localparam logic [6:0] CFG_RESET = 7'h79;
    // command field positions
    localparam int CMD_WRITE = 0;
    localparam int CMD_LANE0 = 8;
    // timing counts
    localparam logic [1:0] LOOKUP_CYCLES = 2'h3;
    localparam logic [1:0] LAST_BEAT     = 2'h3;
    localparam int         LANES         = 8;
    // access sequencer states
    typedef enum logic [2:0] {L2PI_IDLE, L2PI_LOOKUP, L2PI_DATA, L2PI_TAGWR} l2pi_state_type;
endpackage : l2pi_pkg

// File: l2pi_top.sv
// Purpose: secondary cache pin sequencer with second processor arbitration
// Assumes: pin inputs are asynchronous and are synchronised here
// Notes: one command runs lookup, then, except on a write miss, four beats and an optional tag write
`timescale 1ns/10ps
module l2pi_top
(
    input  wire logic             clk_i,
    input  wire logic             rst_i,
    input  wire logic             wb_cyc_i,
    input  wire logic             wb_stb_i,
    input  wire logic             wb_we_i,
    input  wire logic [7:0]       wb_adr_i,
    input  wire logic [3:0]       wb_sel_i,
    input  wire logic [31:0]      wb_dat_i,
    output logic      [31:0]      wb_dat_o,
    output logic                  wb_ack_o,
    input  wire logic             line_modified_in_or_req2_i,
    input  wire logic             hit_i,
    input  wire logic             primary_addr_grant_i,
    input  wire logic             data_bus_busy_i,
    input  wire logic             address_retry_i,
    output logic                  addr_strobe_or_latch_enable_o,
    output logic                  burst_advance_or_beat_lsb_o,
    output logic                  tag_latch_en_or_beat_msb_o,
    output logic                  mark_modified_out_or_grant2_o,
    output logic                  tag_out_en_or_data_grant2_o,
    output logic                  data_ram_out_en_o,
    output logic                  latch_drive_en_o,
    output logic                  tag_write_en_o,
    output logic                  line_valid_out_o,
    output logic [7:0]            lane_write_enables_o
);
    logic [6:0]                   cfg_ff;
    logic                         ack_ff;
    logic [31:0]                  rdat_ff;
    logic                         start_ff;
    logic                         cmd_write_ff;
    logic [7:0]                   cmd_lanes_ff;
    l2pi_pkg::l2pi_state_type     state_ff;
    logic [1:0]                   cnt_ff;
    logic                         hit_seen_ff;
    logic                         dirty_seen_ff;
    logic [1:0]                   sync_req_ff;
    logic [1:0]                   sync_hit_ff;
    logic [1:0]                   sync_gnt_ff;
    logic [1:0]                   sync_busy_ff;
    logic [1:0]                   sync_retry_ff;
    logic                         agrant_ff;
    logic                         dgrant_ff;
    logic                         strobe_ff;
    logic                         adv_ff;
    logic                         talat_ff;
    logic                         mark_ff;
    logic                         tagoe_ff;
    logic                         ramoe_ff;
    logic                         latoe_ff;
    logic                         tagwe_ff;
    logic                         valid_ff;
    logic [7:0]                   lanes_ff;
    logic                         nxt_strobe;
    logic                         nxt_adv;
    logic                         nxt_talat;
    logic                         nxt_mark;
    logic                         nxt_tagoe;
    logic                         nxt_ramoe;
    logic                         nxt_latoe;
    logic                         nxt_tagwe;
    logic                         nxt_valid;
    logic [7:0]                   nxt_lanes;
    logic                         bus_req;
    logic                         wr_cfg;
    logic                         wr_cmd;
    logic                         burst_mode;
    logic                         cpu2_mode;
    logic                         dirty_act;
    logic                         hit_act;
    logic                         req2_act;
    logic                         in_lookup;
    logic                         in_data;
    logic                         in_tagwr;
    logic                         beat_write;

    assign bus_req    = wb_cyc_i && wb_stb_i && !ack_ff;
    assign wr_cfg     = bus_req && wb_we_i && (wb_adr_i == l2pi_pkg::ADDR_CFG) && wb_sel_i[0];
    assign wr_cmd     = bus_req && wb_we_i && (wb_adr_i == l2pi_pkg::ADDR_CMD);
    assign burst_mode = cfg_ff[l2pi_pkg::CFG_BURST];
    assign cpu2_mode  = cfg_ff[l2pi_pkg::CFG_CPU2];

    // wishbone ack, one cycle after the strobe, dropped the next cycle
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
            ack_ff <= 1'b0;
        else
            ack_ff <= bus_req;
    end

    always_ff @(posedge clk_i)
    begin
        if (rst_i)
            cfg_ff <= l2pi_pkg::CFG_RESET;
        else if (wr_cfg && (state_ff == l2pi_pkg::L2PI_IDLE))
            cfg_ff <= wb_dat_i[6:0];
    end

    // command capture; ignored while busy; in second processor mode the fields are stored but no start is raised
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            start_ff     <= 1'b0;
            cmd_write_ff <= 1'b0;
            cmd_lanes_ff <= 8'h00;
        end
        else
        begin
            start_ff <= wr_cmd && wb_sel_i[0] && !cpu2_mode && (state_ff == l2pi_pkg::L2PI_IDLE) && !start_ff;
            if (wr_cmd && (state_ff == l2pi_pkg::L2PI_IDLE) && !start_ff)
            begin
                if (wb_sel_i[0])
                    cmd_write_ff <= wb_dat_i[l2pi_pkg::CMD_WRITE];
                if (wb_sel_i[1])
                    cmd_lanes_ff <= wb_dat_i[l2pi_pkg::CMD_LANE0 +: 8];
            end
        end
    end

    // read data mux, unmapped offsets read zero
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
            rdat_ff <= 32'h0000_0000;
        else if (bus_req && !wb_we_i)
        begin
            unique case (wb_adr_i)
                l2pi_pkg::ADDR_CFG:    rdat_ff <= {25'h0000000, cfg_ff};
                l2pi_pkg::ADDR_CMD:    rdat_ff <= {16'h0000, cmd_lanes_ff, 7'h00, cmd_write_ff};
                l2pi_pkg::ADDR_STATUS: rdat_ff <= {26'h0000000, dgrant_ff, agrant_ff, req2_act,
                                                   dirty_seen_ff, hit_seen_ff,
                                                   state_ff != l2pi_pkg::L2PI_IDLE};
                default:               rdat_ff <= 32'h0000_0000;
            endcase
        end
    end
    assign wb_dat_o = rdat_ff;
    assign wb_ack_o = ack_ff;

    // two flop synchronisers for all pin inputs
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            sync_req_ff   <= 2'h0;
            sync_hit_ff   <= 2'h0;
            sync_gnt_ff   <= 2'h0;
            sync_busy_ff  <= 2'h0;
            sync_retry_ff <= 2'h0;
        end
        else
        begin
            sync_req_ff   <= {sync_req_ff[0], line_modified_in_or_req2_i};
            sync_hit_ff   <= {sync_hit_ff[0], hit_i};
            sync_gnt_ff   <= {sync_gnt_ff[0], primary_addr_grant_i};
            sync_busy_ff  <= {sync_busy_ff[0], data_bus_busy_i};
            sync_retry_ff <= {sync_retry_ff[0], address_retry_i};
        end
    end

    assign dirty_act = sync_req_ff[1] ~^ cfg_ff[l2pi_pkg::CFG_DIRTY_POL];
    assign hit_act   = sync_hit_ff[1] ~^ cfg_ff[l2pi_pkg::CFG_HIT_POL];
    assign req2_act  = cpu2_mode && sync_req_ff[1];

    // access sequencer: lookup, four beats, tag update
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            state_ff      <= l2pi_pkg::L2PI_IDLE;
            cnt_ff        <= 2'h0;
            hit_seen_ff   <= 1'b0;
            dirty_seen_ff <= 1'b0;
        end
        else
        begin
            unique case (state_ff)
                l2pi_pkg::L2PI_IDLE:
                begin
                    cnt_ff <= 2'h0;
                    if (start_ff)
                        state_ff <= l2pi_pkg::L2PI_LOOKUP;
                end
                l2pi_pkg::L2PI_LOOKUP:
                begin
                    cnt_ff <= cnt_ff + 2'h1;
                    if (cnt_ff == l2pi_pkg::LOOKUP_CYCLES)
                    begin
                        hit_seen_ff   <= hit_act;
                        dirty_seen_ff <= dirty_act;
                        cnt_ff        <= 2'h0;
                        // a write miss ends without touching the line
                        state_ff <= (cmd_write_ff && !hit_act) ? l2pi_pkg::L2PI_IDLE : l2pi_pkg::L2PI_DATA;
                    end
                end
                l2pi_pkg::L2PI_DATA:
                begin
                    cnt_ff <= cnt_ff + 2'h1;
                    if (cnt_ff == l2pi_pkg::LAST_BEAT)
                        state_ff <= (cmd_write_ff || !hit_seen_ff) ? l2pi_pkg::L2PI_TAGWR : l2pi_pkg::L2PI_IDLE;
                end
                l2pi_pkg::L2PI_TAGWR:
                    state_ff <= l2pi_pkg::L2PI_IDLE;
            endcase
        end
    end

    assign in_lookup  = state_ff == l2pi_pkg::L2PI_LOOKUP;
    assign in_data    = state_ff == l2pi_pkg::L2PI_DATA;
    assign in_tagwr   = state_ff == l2pi_pkg::L2PI_TAGWR;
    // writes on a write hit and line fill on a read miss
    assign beat_write = in_data && (cmd_write_ff || !hit_seen_ff);

    // next pin values, roles chosen by the mode bits
    always_comb
    begin
        // strobe at lookup start in either sram type
        nxt_strobe = in_lookup && (cnt_ff == 2'h0);
        // advance pulses from the second beat in burst mode
        // async mode drives the beat lsb
        nxt_adv    = burst_mode ? (in_data && (cnt_ff != 2'h0)) : (in_data && cnt_ff[0]);
        // transparent latch during lookup; async beat msb
        nxt_talat  = burst_mode ? in_lookup : (in_data && cnt_ff[1]);
        // latch drives local address bus for lookup and tag write
        nxt_latoe  = in_lookup || in_tagwr;
        // data rams drive the bus on a read hit
        nxt_ramoe  = in_data && !cmd_write_ff && hit_seen_ff;
        // one tag write updates tag, valid and dirty
        nxt_tagwe  = in_tagwr;
        // polarity applied to dirty and valid marks
        nxt_mark   = (in_tagwr && cmd_write_ff) ~^ cfg_ff[l2pi_pkg::CFG_MARK_POL];
        nxt_valid  = in_tagwr ~^ cfg_ff[l2pi_pkg::CFG_VALID_POL];
        // tag ram drives stored tag during lookup
        nxt_tagoe  = in_lookup;
        // three pins become request, address grant, data grant
        if (cpu2_mode)
        begin
            nxt_mark  = agrant_ff;
            nxt_tagoe = dgrant_ff;
        end
    end

    // lane write enables, one generate per lane
    genvar lane;
    generate
        for (lane = 0; lane < l2pi_pkg::LANES; lane = lane + 1)
        begin : g_lane
            if (lane == 1)
                assign nxt_lanes[lane] = beat_write &&
                    (!cfg_ff[l2pi_pkg::CFG_ONCHIP] || cmd_lanes_ff[lane] || !cmd_write_ff);
            else
                assign nxt_lanes[lane] = beat_write && cfg_ff[l2pi_pkg::CFG_ONCHIP] &&
                    (cmd_lanes_ff[lane] || !cmd_write_ff);
        end
    endgenerate

    // second processor arbitration
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            agrant_ff <= 1'b0;
            dgrant_ff <= 1'b0;
        end
        else
        begin
            // address grant while requested and primary not granted
            agrant_ff <= req2_act && !sync_gnt_ff[1];
            // data grant only when bus idle and no retry
            dgrant_ff <= agrant_ff && req2_act && !sync_busy_ff[1] && !sync_retry_ff[1];
        end
    end

    // registered pin outputs
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            strobe_ff <= 1'b0;
            adv_ff    <= 1'b0;
            talat_ff  <= 1'b0;
            mark_ff   <= 1'b0;
            tagoe_ff  <= 1'b0;
            ramoe_ff  <= 1'b0;
            latoe_ff  <= 1'b0;
            tagwe_ff  <= 1'b0;
            valid_ff  <= 1'b0;
            lanes_ff  <= 8'h00;
        end
        else
        begin
            strobe_ff <= nxt_strobe;
            adv_ff    <= nxt_adv;
            talat_ff  <= nxt_talat;
            mark_ff   <= nxt_mark;
            tagoe_ff  <= nxt_tagoe;
            ramoe_ff  <= nxt_ramoe;
            latoe_ff  <= nxt_latoe;
            tagwe_ff  <= nxt_tagwe;
            valid_ff  <= nxt_valid;
            lanes_ff  <= nxt_lanes;
        end
    end

    assign addr_strobe_or_latch_enable_o = strobe_ff;
    assign burst_advance_or_beat_lsb_o   = adv_ff;
    assign tag_latch_en_or_beat_msb_o    = talat_ff;
    assign mark_modified_out_or_grant2_o = mark_ff;
    assign tag_out_en_or_data_grant2_o   = tagoe_ff;
    assign data_ram_out_en_o             = ramoe_ff;
    assign latch_drive_en_o              = latoe_ff;
    assign tag_write_en_o                = tagwe_ff;
    assign line_valid_out_o              = valid_ff;
    assign lane_write_enables_o          = lanes_ff;

    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);

    a_strobe_follows_start: assert property (start_ff |-> ##2 addr_strobe_or_latch_enable_o)
        else $error("strobe missing after start");
    a_burst_advance: assert property ((in_data && burst_mode && cnt_ff == 2'h1) |=> burst_advance_or_beat_lsb_o)
        else $error("burst advance missing");
    a_async_lsb: assert property ((!cpu2_mode && !burst_mode && $stable(cfg_ff)) |=> (burst_advance_or_beat_lsb_o == $past(in_data && cnt_ff[0])))
        else $error("beat lsb wrong");
    a_async_msb: assert property ((!burst_mode && in_data && cnt_ff == 2'h2 && $stable(cfg_ff)) |=> tag_latch_en_or_beat_msb_o)
        else $error("beat msb wrong");
    a_tag_write_once: assert property (tag_write_en_o |=> !tag_write_en_o)
        else $error("tag write longer than one cycle");
    a_tag_write_latch: assert property (tag_write_en_o |-> latch_drive_en_o)
        else $error("latch not driving during tag write");
    a_ramoe_no_write: assert property (data_ram_out_en_o |-> (lane_write_enables_o == 8'h00))
        else $error("data ram enabled while writing");
    a_ext_decode_one: assert property ((!cfg_ff[l2pi_pkg::CFG_ONCHIP] && $stable(cfg_ff)) |=> ((lane_write_enables_o & 8'hfd) == 8'h00))
        else $error("extra strobe with external decode");
    a_grant_needs_req: assert property (mark_modified_out_or_grant2_o && cpu2_mode && $stable(cfg_ff) |-> $past(req2_act, 2))
        else $error("address grant without request");
    a_dgrant_after_agrant: assert property ((dgrant_ff) |-> $past(agrant_ff))
        else $error("data grant before address grant");
endmodule : l2pi_top

// File: test_l2_cache_pin_interface.sv
// Purpose: self-checking bench for the cache pin sequencer
// Assumes: register bus answers one cycle after a request
// Notes: pin activity is counted per command and compared
`timescale 1ns/10ps
module test_l2_cache_pin_interface;
    typedef struct packed {logic [6:0] cfg; logic [15:0] cmd; logic [1:0] hd; logic [79:0] e;} l2pi_row_type;
    logic             clk_i, rst_i, wb_cyc, wb_stb, wb_we, clr, watch;
    logic [7:0]       wb_adr;
    logic [3:0]       wb_sel;
    logic [31:0]      wb_dat, q;
    logic             hit_want, dirty_want, req_want, pag, bbusy, retry;
    logic [6:0]       cfg_now;
    wire logic        astb, adv, tlat, mark, tag_oe, ram_oe, ldrv, tag_we, valid, mreq, hit, owns, wb_ack;
    wire logic [7:0]  lanes;
    wire logic [31:0] wb_rd;
    logic [9:0]       act;
    logic [7:0]       cnt [10];
    l2pi_row_type     rows [8];
    logic [5:0]       arb [5];
    int               n_fail = 0;
    int               cmp_count = 0;

    l2pi_top dut
    (
        .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc), .wb_stb_i(wb_stb), .wb_we_i(wb_we),
        .wb_adr_i(wb_adr), .wb_sel_i(wb_sel), .wb_dat_i(wb_dat), .wb_dat_o(wb_rd), .wb_ack_o(wb_ack),
        .line_modified_in_or_req2_i(mreq), .hit_i(hit), .primary_addr_grant_i(pag),
        .data_bus_busy_i(bbusy), .address_retry_i(retry), .addr_strobe_or_latch_enable_o(astb),
        .burst_advance_or_beat_lsb_o(adv), .tag_latch_en_or_beat_msb_o(tlat),
        .mark_modified_out_or_grant2_o(mark), .tag_out_en_or_data_grant2_o(tag_oe),
        .data_ram_out_en_o(ram_oe), .latch_drive_en_o(ldrv), .tag_write_en_o(tag_we),
        .line_valid_out_o(valid), .lane_write_enables_o(lanes)
    );

    l2pi_far_model far
    (
        .clk_i(clk_i), .cpu2_i(cfg_now[2]), .dpol_i(cfg_now[3]), .hpol_i(cfg_now[4]),
        .hit_want_i(hit_want), .dirty_want_i(dirty_want), .req_want_i(req_want),
        .agrant_i(mark), .dgrant_i(tag_oe), .busy_i(bbusy), .retry_i(retry),
        .mod_req_o(mreq), .hit_o(hit), .owns_o(owns)
    );

    // clock at 50 MHz
    initial
    begin
        clk_i = 1'b0;
        forever #10 clk_i = ~clk_i;
    end

    // pin activity, mark and valid judged by their polarity
    always_comb act = {ldrv, mark ~^ cfg_now[5], valid ~^ cfg_now[6], tag_we, 1'b0, ram_oe, tag_oe, tlat, adv, astb};

    // count active cycles of each pin while watching
    always @(posedge clk_i)
    begin
        for (int i = 0; i < 10; i++)
        begin
            if (clr)
                cnt[i] <= 8'h00;
            else if (watch)
                cnt[i] <= cnt[i] + ((i == 5) ? 8'($countones(lanes)) : {7'h00, act[i]});
        end
    end

    task automatic chk(input logic [31:0] s, input logic [31:0] e);
    begin
        cmp_count++;
        if (s !== e)
        begin
            n_fail++;
            $display("CHECK FAILED t=%0t seen %h expected %h", $time, s, e);
        end
    end
    endtask : chk

    // one classic bus cycle, held until ack is sampled
    task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] r);
        int n;
    begin
        n = 0;
        wb_cyc <= 1'b1;
        wb_stb <= 1'b1;
        wb_we  <= w;
        wb_adr <= a;
        wb_dat <= d;
        @(posedge clk_i);
        // wait for the answer however long it takes; the watchdog ends a hang
        while (wb_ack !== 1'b1)
        begin
            @(posedge clk_i);
            n++;
        end
        chk(n, 32'h1);
        r = wb_rd;
        wb_cyc <= 1'b0;
        wb_stb <= 1'b0;
        wb_we  <= 1'b0;
        @(posedge clk_i);
    end
    endtask : wb

    task automatic setcfg(input logic [6:0] c);
    begin
        wb(1'b1, l2pi_pkg::ADDR_CFG, {25'h0, c}, q);
        cfg_now <= c;
    end
    endtask : setcfg

    // poll busy until the sequencer is idle again
    task automatic wait_idle;
        int n;
    begin
        n = 0;
        wb(1'b0, l2pi_pkg::ADDR_STATUS, 32'h0, q);
        while (q[0] !== 1'b0 && n < 40)
        begin
            wb(1'b0, l2pi_pkg::ADDR_STATUS, 32'h0, q);
            n++;
        end
        chk({31'h0, q[0]}, 32'h0);
    end
    endtask : wait_idle

    task automatic run(input logic [15:0] c);
    begin
        clr <= 1'b1;
        @(posedge clk_i);
        clr   <= 1'b0;
        watch <= 1'b1;
        wb(1'b1, l2pi_pkg::ADDR_CMD, {16'h0, c}, q);
        wait_idle;
        repeat (4) @(posedge clk_i);
        watch <= 1'b0;
        @(posedge clk_i);
    end
    endtask : run

    // all pins idle and bus quiet
    task automatic rchk;
    begin
        chk({14'h0, astb, adv, tlat, mark, tag_oe, ram_oe, ldrv, tag_we, valid, lanes, wb_ack}, 32'h0);
        wb(1'b0, l2pi_pkg::ADDR_CFG, 32'h0, q);
        chk({25'h0, q[6:0]}, {25'h0, l2pi_pkg::CFG_RESET});
    end
    endtask : rchk

    task results;
    begin
        $display("comparisons %0d mismatches %0d", cmp_count, n_fail);
        if (n_fail == 0 && cmp_count > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    end
    endtask : results

    // watchdog against a hung handshake
    initial
    begin
        #400000;
        n_fail++;
        results;
    end

    // main sequence: cfg, cmd, {hit,dirty}, counts of strobe adv tlat tagoe ramoe lanes tagwe valid mark ldrv
    initial
    begin
        rst_i = 1'b1;
        {wb_cyc, wb_stb, wb_we, wb_adr, wb_dat, clr, watch} = '0;
        wb_sel = 4'hf;
        {hit_want, dirty_want, req_want, pag, bbusy, retry} = '0;
        cfg_now = l2pi_pkg::CFG_RESET;
        rows[0] = {7'h79, 16'h0000, 2'b10, 80'h01030404040000000004};
        rows[1] = {7'h79, 16'h0000, 2'b01, 80'h01030404000401010005};
        rows[2] = {7'h7b, 16'ha501, 2'b10, 80'h01030404001001010105};
        rows[3] = {7'h79, 16'h0001, 2'b00, 80'h01000404000000000004};
        rows[4] = {7'h78, 16'h0000, 2'b11, 80'h01020204040000000004};
        rows[5] = {7'h7a, 16'h0000, 2'b00, 80'h01020204002001010005};
        rows[6] = {7'h19, 16'h0001, 2'b11, 80'h01030404000401010105};
        rows[7] = {7'h61, 16'h0000, 2'b11, 80'h01030404040000000004};
        arb = '{6'b100011, 6'b101010, 6'b100110, 6'b110000, 6'b000000};
        repeat (2) @(posedge clk_i);
        rst_i <= 1'b0;
        repeat (2) @(posedge clk_i);
        rchk;
        for (int r = 0; r < 8; r++)
        begin
            setcfg(rows[r].cfg);
            {hit_want, dirty_want} <= rows[r].hd;
            run(rows[r].cmd);
            for (int i = 0; i < 10; i++)
                chk({24'h0, cnt[i]}, {24'h0, rows[r].e[79-8*i -: 8]});
            wb(1'b0, l2pi_pkg::ADDR_STATUS, 32'h0, q);
            chk({30'h0, q[2:1]}, {30'h0, rows[r].hd[0], rows[r].hd[1]});
        end
        // unmapped and read-only places
        wb(1'b1, 8'h0c, 32'hffffffff, q);
        wb(1'b0, 8'h0c, 32'h0, q);
        chk(q, 32'h0);
        wb(1'b1, l2pi_pkg::ADDR_STATUS, 32'h3f, q);
        wb(1'b0, l2pi_pkg::ADDR_STATUS, 32'h0, q);
        chk({31'h0, q[0]}, 32'h0);
        // configuration held while a command runs
        setcfg(7'h79);
        wb(1'b1, l2pi_pkg::ADDR_CMD, 32'h0, q);
        wb(1'b1, l2pi_pkg::ADDR_CFG, 32'h7d, q);
        wait_idle;
        wb(1'b0, l2pi_pkg::ADDR_CFG, 32'h0, q);
        chk({25'h0, q[6:0]}, 32'h79);
        // reset in the middle of an access
        setcfg(7'h7b);
        wb(1'b1, l2pi_pkg::ADDR_CMD, 32'h0, q);
        repeat (3) @(posedge clk_i);
        rst_i <= 1'b1;
        repeat (2) @(posedge clk_i);
        rst_i <= 1'b0;
        cfg_now <= l2pi_pkg::CFG_RESET;
        repeat (2) @(posedge clk_i);
        rchk;
        // second processor mode: commands refused, pins become grants
        setcfg(7'h7d);
        run(16'h0001);
        chk({24'h0, cnt[0]}, 32'h0);
        for (int k = 0; k < 5; k++)
        begin
            {req_want, pag, bbusy, retry} <= arb[k][5:2];
            repeat (8) @(posedge clk_i);
            chk({30'h0, mark, tag_oe}, {30'h0, arb[k][1:0]});
            chk({31'h0, owns}, {31'h0, arb[k][0]});
            wb(1'b0, l2pi_pkg::ADDR_STATUS, 32'h0, q);
            chk({30'h0, q[5:4]}, {30'h0, arb[k][0], arb[k][1]});
        end
        results;
    end
endmodule : test_l2_cache_pin_interface
